/* sspu_pkg.sv */
// Package of offsets, fields and reset values for the status/sync/power-down/update registers
package sspu_pkg;
  localparam logic [11:0] ADDR_STATUS_PIN_CONFIG = 12'h232;
  localparam logic [11:0] ADDR_POWER_DOWN_CONTROL = 12'h233;
  localparam logic [11:0] ADDR_UPDATE_ALL_REGISTERS = 12'h234;
  localparam logic [11:0] ADDR_MON_SEL_FIRST = 12'h230;
  localparam logic [11:0] ADDR_MON_SEL_SECOND = 12'h231;
  // Field positions
  localparam int SPC_SYNC_BIT = 0;
  localparam int SPC_DIV_FIRST_BIT = 2;
  localparam int SPC_DIV_SECOND_BIT = 3;
  localparam int SPC_NV_ON_FIRST_BIT = 4;
  localparam int PDC_DIST_BIT = 0;
  localparam int PDC_SYNTH_BIT = 1;
  localparam int PDC_CLEANUP_BIT = 2;
  localparam int UPD_BIT = 0;
  // Writable masks; reserved bits stay zero
  localparam logic [7:0] SPC_MASK = 8'h1d;
  localparam logic [7:0] PDC_MASK = 8'h07;
  localparam logic [7:0] MON_MASK = 8'h3f;
  // Reset values
  localparam logic [7:0] SPC_RESET = 8'h00;
  localparam logic [7:0] PDC_RESET = 8'h07;
  localparam logic [7:0] MON_RESET = 8'h00;
  // Monitor selector codes
  localparam logic [5:0] MON_STATIC_LAST = 6'h0f;
  localparam logic [5:0] MON_SYNTH_REF_DIV2 = 6'h16;
  localparam logic [5:0] MON_SYNTH_UP_DIV2 = 6'h17;
endpackage : sspu_pkg

/* sspu_regs.sv */
// Status-pin, sync, power-down and update register group of the clock generator
//
// Operation
// - code 0x16 ref/2, 0x17 up/2
// - bit4 routes transfer-pending flag to first pin
// - bit3 divides second status pin by four
// - bit2 divides first status pin by four unless bit4 is set
// - bit0 holds output dividers in sync
// - power-down bit0 gates distribution, default one
// - bits 2,1 power down loops, default one
// - update bit copies buffers to active
// - update bit clears itself after transfer
`timescale 1ns/100ps
module sspu_regs
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [11:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_nv_pending,
  input wire logic [7:0] i_mon_sigs,
  output logic [7:0] o_rdata,
  output logic o_status_out_first,
  output logic o_status_out_second,
  output logic o_sync_hold,
  output logic o_pd_dist,
  output logic o_pd_synth_loop,
  output logic o_pd_input_cleanup_loop
);
  import sspu_pkg::*;

  // Monitor inputs: [0]=synth ref, [1]=synth PFD up, others generic dynamic sources
  typedef enum logic [0:0] {SSPU_IDLE = 1'b0, SSPU_COMMIT = 1'b1} sspu_state_e;

  // Picks a monitor signal for a selector code
  function automatic logic sspu_mon_pick(input logic [5:0] code, input logic [7:0] sigs);
    logic r;
    r = 1'b0;
    if (code == MON_SYNTH_REF_DIV2) begin
      r = sigs[0];
    end else if (code == MON_SYNTH_UP_DIV2) begin
      r = sigs[1];
    end else if (code > MON_STATIC_LAST) begin
      r = sigs[code[2:0]];
    end
    return r;
  endfunction : sspu_mon_pick

  // Buffer copies, written by the host
  logic [7:0] buf_spc;
  logic [7:0] buf_pdc;
  logic [5:0] buf_mon0;
  logic [5:0] buf_mon1;
  // Active copies, steering the outputs
  logic [7:0] act_spc;
  logic [7:0] act_pdc;
  logic [5:0] act_mon0;
  logic [5:0] act_mon1;
  sspu_state_e state;
  // Divider chain for /2 codes and /4 options
  logic [1:0] div2; // Half-rate stages, one per pin
  logic [1:0] prev; // Last raw source level, for the /2 edge detect
  logic [1:0] prev_sel; // Last selected level, for the /4 edge detect
  logic [1:0] cnt0;
  logic [1:0] cnt1;

  // Decodes
  // Only a one written to the update address arms the commit; a zero is ignored
  wire wr_spc = i_wr && (i_addr == ADDR_STATUS_PIN_CONFIG);
  wire wr_pdc = i_wr && (i_addr == ADDR_POWER_DOWN_CONTROL);
  wire wr_upd = i_wr && (i_addr == ADDR_UPDATE_ALL_REGISTERS) && i_wdata[UPD_BIT];
  wire wr_m0 = i_wr && (i_addr == ADDR_MON_SEL_FIRST);
  wire wr_m1 = i_wr && (i_addr == ADDR_MON_SEL_SECOND);
  wire raw0 = sspu_mon_pick(act_mon0, i_mon_sigs);
  wire raw1 = sspu_mon_pick(act_mon1, i_mon_sigs);
  // Selector codes from 0x16 up use a toggling stage; lower codes pass raw
  wire sel0 = (act_mon0 >= MON_SYNTH_REF_DIV2) ? div2[0] : raw0;
  wire sel1 = (act_mon1 >= MON_SYNTH_REF_DIV2) ? div2[1] : raw1;
  // Update bit reads as one only while the commit is still pending
  wire upd_flag = (state == SSPU_COMMIT);
  wire [7:0] next_rdata =
    (i_addr == ADDR_STATUS_PIN_CONFIG) ? buf_spc :
    (i_addr == ADDR_POWER_DOWN_CONTROL) ? buf_pdc :
    (i_addr == ADDR_UPDATE_ALL_REGISTERS) ? {7'h00, upd_flag} :
    (i_addr == ADDR_MON_SEL_FIRST) ? {2'b00, buf_mon0} :
    (i_addr == ADDR_MON_SEL_SECOND) ? {2'b00, buf_mon1} : 8'h00;
  wire next_first = act_spc[SPC_NV_ON_FIRST_BIT] ? i_nv_pending :
    (act_spc[SPC_DIV_FIRST_BIT] ? cnt0[1] : sel0);
  wire next_second = act_spc[SPC_DIV_SECOND_BIT] ? cnt1[1] : sel1;

  // Host writes go to buffers only; reserved bits masked off
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      buf_spc <= SPC_RESET;
      buf_pdc <= PDC_RESET;
      buf_mon0 <= MON_RESET[5:0];
      buf_mon1 <= MON_RESET[5:0];
    end else begin
      if (wr_spc) buf_spc <= i_wdata & SPC_MASK;
      if (wr_pdc) buf_pdc <= i_wdata & PDC_MASK;
      if (wr_m0) buf_mon0 <= i_wdata[5:0] & MON_MASK[5:0];
      if (wr_m1) buf_mon1 <= i_wdata[5:0] & MON_MASK[5:0];
    end
  end

  // Commit: the write arms it, the next edge copies, then the bit clears itself.
  // One cycle stands in for the next serial clock edge of the control port.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= SSPU_IDLE;
      act_spc <= SPC_RESET;
      act_pdc <= PDC_RESET;
      act_mon0 <= MON_RESET[5:0];
      act_mon1 <= MON_RESET[5:0];
    end else begin
      case (state)
        SSPU_IDLE: begin
          if (wr_upd) state <= SSPU_COMMIT;
        end
        SSPU_COMMIT: begin
          act_spc <= buf_spc;
          act_pdc <= buf_pdc;
          act_mon0 <= buf_mon0;
          act_mon1 <= buf_mon1;
          state <= wr_upd ? SSPU_COMMIT : SSPU_IDLE;
        end
        // Unreachable with a one-bit state, kept so a glitch cannot wedge the commit
        default: state <= SSPU_IDLE;
      endcase
    end
  end

  // Dividers for the status pins. The /2 stage counts rising edges of the raw source;
  // the /4 stage counts rising edges of what the pin would otherwise show, so a /4
  // stacks on top of a /2 selection. Edge detects start at the idle low level.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      div2 <= 2'b00;
      prev <= 2'b00;
      prev_sel <= 2'b00;
      cnt0 <= 2'b00;
      cnt1 <= 2'b00;
    end else begin
      prev <= {raw1, raw0};
      prev_sel <= {sel1, sel0};
      if (raw0 && !prev[0]) div2[0] <= ~div2[0];
      if (raw1 && !prev[1]) div2[1] <= ~div2[1];
      if (sel0 && !prev_sel[0]) cnt0 <= cnt0 + 2'd1;
      if (sel1 && !prev_sel[1]) cnt1 <= cnt1 + 2'd1;
    end
  end

  // Registered outputs
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
      o_status_out_first <= 1'b0;
      o_status_out_second <= 1'b0;
      o_sync_hold <= 1'b0;
      o_pd_dist <= 1'b1;
      o_pd_synth_loop <= 1'b1;
      o_pd_input_cleanup_loop <= 1'b1;
    end else begin
      o_rdata <= i_rd ? next_rdata : 8'h00;
      o_status_out_first <= next_first;
      o_status_out_second <= next_second;
      o_sync_hold <= act_spc[SPC_SYNC_BIT];
      o_pd_dist <= act_pdc[PDC_DIST_BIT];
      o_pd_synth_loop <= act_pdc[PDC_SYNTH_BIT];
      o_pd_input_cleanup_loop <= act_pdc[PDC_CLEANUP_BIT];
    end
  end

  // Assertions
  a_pd_follows_active: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    o_pd_dist == $past(act_pdc[PDC_DIST_BIT])) else $error("dist power-down wrong");
  a_loops_follow_active: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    {o_pd_input_cleanup_loop, o_pd_synth_loop} == $past(act_pdc[2:1]))
    else $error("loop power-down wrong");
  a_sync_hold_follows: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    o_sync_hold == $past(act_spc[SPC_SYNC_BIT])) else $error("sync hold wrong");
  a_update_commits: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (state == SSPU_IDLE && wr_upd) |=> ##1 (act_pdc == $past(buf_pdc)))
    else $error("update did not copy");
  a_update_selfclear: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (state == SSPU_COMMIT && !wr_upd) |=> state == SSPU_IDLE)
    else $error("update bit stuck");
  a_no_early_effect: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (state == SSPU_IDLE) |=> $stable(act_spc) && $stable(act_pdc))
    else $error("active changed without update");
  a_reserved_zero: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (buf_spc & ~SPC_MASK) == 8'h00 && (buf_pdc & ~PDC_MASK) == 8'h00)
    else $error("reserved bit set");
  a_nv_on_first: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    act_spc[SPC_NV_ON_FIRST_BIT] |=> o_status_out_first == $past(i_nv_pending))
    else $error("pending flag not on pin");
  a_div_second: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    act_spc[SPC_DIV_SECOND_BIT] |=> o_status_out_second == $past(cnt1[1]))
    else $error("second pin not divided");
  a_div_first: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (act_spc[SPC_DIV_FIRST_BIT] && !act_spc[SPC_NV_ON_FIRST_BIT])
    |=> o_status_out_first == $past(cnt0[1])) else $error("first pin not divided");
  // The /4 counter must step on every rising edge of the selection, not of the raw source
  a_quarter_count: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (sel0 && !prev_sel[0]) |=> cnt0 == $past(cnt0) + 2'd1)
    else $error("first pin quarter counter missed an edge");
  a_half_rate_toggle: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (raw0 && !prev[0]) |=> div2[0] != $past(div2[0]))
    else $error("half-rate stage missed an edge");
  a_ref_half_on_first: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (act_mon0 == MON_SYNTH_REF_DIV2 && !act_spc[SPC_NV_ON_FIRST_BIT]
      && !act_spc[SPC_DIV_FIRST_BIT]) |=> o_status_out_first == $past(div2[0]))
    else $error("first pin not at half reference rate");
  // Main scenarios: a commit reaching the pins, sync release, divides, routing, half rate
  c_update: cover property (@(posedge i_core_clk) disable iff (i_rst) wr_upd ##3 o_pd_dist == 1'b0);
  c_sync: cover property (@(posedge i_core_clk) disable iff (i_rst) o_sync_hold ##1 !o_sync_hold);
  c_div: cover property (@(posedge i_core_clk) disable iff (i_rst) act_spc[SPC_DIV_FIRST_BIT]);
  c_nv_route: cover property (@(posedge i_core_clk) disable iff (i_rst)
    act_spc[SPC_NV_ON_FIRST_BIT] && i_nv_pending);
  c_ref_half: cover property (@(posedge i_core_clk) disable iff (i_rst)
    act_mon0 == MON_SYNTH_REF_DIV2 && act_mon1 == MON_SYNTH_UP_DIV2);
endmodule : sspu_regs

/* sspu_src_model.sv */
// Model of the monitored clock sources behind the status pins
`timescale 1ns/100ps
module sspu_src_model (
  input wire logic i_core_clk,
  input wire logic i_rst,
  output logic [7:0] o_mon_sigs
);
  // Free counter: bit 0 acts as synth ref (period 2), bit 1 as PFD up (period 4)
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_mon_sigs <= 8'h00;
    end else begin
      o_mon_sigs <= o_mon_sigs + 8'h01;
    end
  end
endmodule : sspu_src_model

/* tb.sv */
// Self-checking bench for the status/sync/power-down/update registers
`timescale 1ns/100ps
module tb;
  import sspu_pkg::*;
  logic i_core_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_nv_pending = 1'b0;
  logic [11:0] i_addr = 12'h000;
  logic [7:0] i_wdata = 8'h00, i_mon_sigs, o_rdata;
  logic o_status_out_first, o_status_out_second, o_sync_hold;
  logic o_pd_dist, o_pd_synth_loop, o_pd_input_cleanup_loop;
  int n_errors = 0, compares = 0;
  // Power-down and sync outputs packed for one compare
  wire [7:0] pd_sync = {4'h0, o_pd_dist, o_pd_synth_loop, o_pd_input_cleanup_loop,
    o_sync_hold};
  sspu_src_model src (.i_core_clk(i_core_clk), .i_rst(i_rst), .o_mon_sigs(i_mon_sigs));
  sspu_regs uut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_wr(i_wr), .i_rd(i_rd),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_nv_pending(i_nv_pending), .i_mon_sigs(i_mon_sigs),
    .o_rdata(o_rdata), .o_status_out_first(o_status_out_first),
    .o_status_out_second(o_status_out_second), .o_sync_hold(o_sync_hold),
    .o_pd_dist(o_pd_dist), .o_pd_synth_loop(o_pd_synth_loop),
    .o_pd_input_cleanup_loop(o_pd_input_cleanup_loop));
  // Clock of 40 ns period
  initial begin
    forever #20 i_core_clk = ~i_core_clk;
  end
  // Compare one value; a mismatch is printed at once
  task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One write strobe, held through its taking edge
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge i_core_clk) #1;
    i_wr = 1'b1; i_addr = a; i_wdata = d;
    @(posedge i_core_clk) #1;
    i_wr = 1'b0; i_wdata = ~d;
  endtask : wr
  // One read; data is registered and looked at the cycle after the taking edge
  task rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge i_core_clk) #1;
    i_rd = 1'b1; i_addr = a;
    @(posedge i_core_clk) #1;
    i_rd = 1'b0;
    chk(o_rdata, exp);
  endtask : rd
  // Commit buffers, then wait until outputs have moved (two edges)
  task commit;
    wr(ADDR_UPDATE_ALL_REGISTERS, 8'h01);
    repeat (2) @(posedge i_core_clk);
    #1;
  endtask : commit
  // Count rising edges on both status pins over 128 cycles; sources are periodic, counts exact
  task edges(input int e0, input int e1);
    int c0, c1;
    logic p0, p1;
    c0 = 0; c1 = 0; p0 = o_status_out_first; p1 = o_status_out_second;
    repeat (128) begin
      @(posedge i_core_clk) #1;
      c0 += int'(o_status_out_first & ~p0); c1 += int'(o_status_out_second & ~p1);
      p0 = o_status_out_first; p1 = o_status_out_second;
    end
    chk(8'(c0), 8'(e0));
    chk(8'(c1), 8'(e1));
  endtask : edges
  // Verdict and end of run
  task stop_test;
    if (n_errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  // Watchdog: tests need about 320 cycles
  initial begin
    #200000;
    n_errors++;
    stop_test();
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge i_core_clk);
    #1 i_rst = 1'b0;
    chk(pd_sync, 8'h0e);
    rd(ADDR_POWER_DOWN_CONTROL, 8'h07);
    rd(ADDR_STATUS_PIN_CONFIG, 8'h00);
    rd(12'h235, 8'h00);
    wr(ADDR_STATUS_PIN_CONFIG, 8'hff);
    rd(ADDR_STATUS_PIN_CONFIG, 8'h1d);
    wr(ADDR_POWER_DOWN_CONTROL, 8'hf8);
    rd(ADDR_POWER_DOWN_CONTROL, 8'h00);
    chk(pd_sync, 8'h0e);
    commit();
    chk(pd_sync, 8'h01);
    rd(ADDR_UPDATE_ALL_REGISTERS, 8'h00);
    wr(ADDR_POWER_DOWN_CONTROL, 8'h05);
    commit();
    chk(pd_sync, 8'h0b);
    // Divides stay off with a static selection; only valid codes are programmed
    wr(ADDR_STATUS_PIN_CONFIG, 8'h10);
    i_nv_pending = 1'b1;
    commit();
    chk({7'h00, o_status_out_first}, 8'h01);
    i_nv_pending = 1'b0;
    repeat (3) @(posedge i_core_clk);
    #1;
    chk({6'h00, o_status_out_first, o_sync_hold}, 8'h00);
    wr(ADDR_MON_SEL_FIRST, {2'b00, MON_SYNTH_REF_DIV2});
    wr(ADDR_MON_SEL_SECOND, {2'b00, MON_SYNTH_UP_DIV2});
    wr(ADDR_STATUS_PIN_CONFIG, 8'h00);
    commit();
    edges(32, 16);
    wr(ADDR_STATUS_PIN_CONFIG, 8'h0c);
    commit();
    edges(8, 4);
    stop_test();
  end
endmodule : tb
